// ---- iprb_interrupt_priority_regs.sv ----
// top: axi4-lite slave holding the six upper interrupt priority registers
module iprb_interrupt_priority_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // axi4-lite write address
   input wire logic [iprb_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [iprb_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // priority fields to the arbiter
   output logic [2:0] crc_error_prio,
   output logic [2:0] uart2_error_prio,
   output logic [2:0] uart1_error_prio,
   output logic [2:0] low_voltage_prio,
   output logic [2:0] charge_time_prio,
   output logic [2:0] uart3_tx_prio,
   output logic [2:0] uart3_rx_prio,
   output logic [2:0] uart3_error_prio,
   output logic [2:0] uart4_error_prio,
   output logic [2:0] usb_otg_prio,
   output logic [2:0] i2c3_master_prio,
   output logic [2:0] i2c3_slave_prio,
   output logic [2:0] spi3_event_prio,
   output logic [2:0] spi3_fault_prio,
   output logic [2:0] uart4_tx_prio,
   output logic [2:0] uart4_rx_prio,
   // per-source enable, low when the field is zero
   output logic [15:0] srcEnable
);
   localparam int N = iprb_pkg::NUM_REGS;
   localparam logic [15:0] MASKS [N] = '{
      iprb_pkg::MASK_CRC_UART_ERR, iprb_pkg::MASK_LOW_VOLTAGE,
      iprb_pkg::MASK_CHARGE_TIME, iprb_pkg::MASK_UART3,
      iprb_pkg::MASK_UART4_USB_I2C3, iprb_pkg::MASK_SPI3_UART4};
   localparam logic [iprb_pkg::ADDR_W-1:0] OFFS [N] = '{
      iprb_pkg::OFS_CRC_UART_ERR, iprb_pkg::OFS_LOW_VOLTAGE,
      iprb_pkg::OFS_CHARGE_TIME, iprb_pkg::OFS_UART3,
      iprb_pkg::OFS_UART4_USB_I2C3, iprb_pkg::OFS_SPI3_UART4};

   //---------------------------------------------------------------------------
   // write channel
   //---------------------------------------------------------------------------
   logic awHeld_reg;
   logic wHeld_reg;
   logic [iprb_pkg::ADDR_W-1:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic bValid_reg;
   logic [1:0] bResp_reg;
   logic awReady_reg;
   logic wReady_reg;

   wire logic awTake = s_axi_awvalid && !awHeld_reg && !bValid_reg;
   wire logic wTake = s_axi_wvalid && !wHeld_reg && !bValid_reg;
   // both halves stored: commit the write and answer
   wire logic wrFire = awHeld_reg && wHeld_reg && !bValid_reg;
   wire logic [N-1:0] wrHit;
   wire logic wrMapped = |wrHit;
   // next state of the holding flags, so that the readies can be flops of their own
   wire logic awHeld_next = (awHeld_reg || awTake) && !wrFire;
   wire logic wHeld_next = (wHeld_reg || wTake) && !wrFire;
   wire logic bValid_next = wrFire || (bValid_reg && !s_axi_bready);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= '0;
         wData_reg <= '0;
         wStrb_reg <= '0;
         bValid_reg <= 1'b0;
         bResp_reg <= iprb_pkg::RESP_OKAY;
      end else begin
         if (awTake) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (wTake) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bValid_reg <= 1'b1;
            bResp_reg <= wrMapped ? iprb_pkg::RESP_OKAY : iprb_pkg::RESP_SLVERR;
         end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
         end
      end
   end

   // readies track the holding state one edge ahead, so they leave the block as flops
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         awReady_reg <= 1'b1;
         wReady_reg <= 1'b1;
      end else begin
         awReady_reg <= !awHeld_next && !bValid_next;
         wReady_reg <= !wHeld_next && !bValid_next;
      end
   end

   assign s_axi_awready = awReady_reg;
   assign s_axi_wready = wReady_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;

   //---------------------------------------------------------------------------
   // register bank
   //---------------------------------------------------------------------------
   logic [15:0] regVal [N];
   // contents after this edge, so the enables below can be flops without a lag
   wire logic [15:0] regNext [N];

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_reg
         assign wrHit[gi] = (awAddr_reg == OFFS[gi]);
         wire logic [15:0] laneMask = {{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}} & MASKS[gi];
         assign regNext[gi] = (wrFire && wrHit[gi]) ?
            ((regVal[gi] & ~laneMask) | (wData_reg[15:0] & laneMask)) : regVal[gi];
         iprb_prio_reg #(.MASK(MASKS[gi])) u_reg (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .wrEn(wrFire && wrHit[gi]),
            .wrData(wData_reg[15:0]),
            .wrStrb(wStrb_reg[1:0]),
            .value(regVal[gi])
         );
      end
   endgenerate

   //---------------------------------------------------------------------------
   // read channel
   //---------------------------------------------------------------------------
   logic rValid_reg;
   logic [31:0] rData_reg;
   logic [1:0] rResp_reg;
   logic [15:0] rdWord;
   logic rdMapped;

   always_comb begin
      rdWord = 16'h0000;
      rdMapped = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (s_axi_araddr == OFFS[i]) begin
            rdWord = regVal[i] & MASKS[i];
            rdMapped = 1'b1;
         end
      end
   end

   wire logic arTake = s_axi_arvalid && !rValid_reg;
   wire logic rValid_next = arTake || (rValid_reg && !s_axi_rready);
   logic arReady_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         arReady_reg <= 1'b1;
      end else begin
         arReady_reg <= !rValid_next;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rValid_reg <= 1'b0;
         rData_reg <= '0;
         rResp_reg <= iprb_pkg::RESP_OKAY;
      end else if (arTake) begin
         rValid_reg <= 1'b1;
         rData_reg <= {16'h0000, rdWord};
         rResp_reg <= rdMapped ? iprb_pkg::RESP_OKAY : iprb_pkg::RESP_SLVERR;
      end else if (rValid_reg && s_axi_rready) begin
         rValid_reg <= 1'b0;
      end
   end

   assign s_axi_arready = arReady_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;

   //---------------------------------------------------------------------------
   // field outputs, straight from the stored bits
   //---------------------------------------------------------------------------
   // binary level 7 highest, 1 lowest enabled
   assign crc_error_prio = regVal[0][iprb_pkg::POS_HI +: 3];
   assign uart2_error_prio = regVal[0][iprb_pkg::POS_MH +: 3];
   assign uart1_error_prio = regVal[0][iprb_pkg::POS_ML +: 3];
   assign low_voltage_prio = regVal[1][iprb_pkg::POS_LO +: 3];
   assign charge_time_prio = regVal[2][iprb_pkg::POS_ML +: 3];
   assign uart3_tx_prio = regVal[3][iprb_pkg::POS_HI +: 3];
   assign uart3_rx_prio = regVal[3][iprb_pkg::POS_MH +: 3];
   assign uart3_error_prio = regVal[3][iprb_pkg::POS_ML +: 3];
   assign uart4_error_prio = regVal[4][iprb_pkg::POS_HI +: 3];
   assign usb_otg_prio = regVal[4][iprb_pkg::POS_MH +: 3];
   assign i2c3_master_prio = regVal[4][iprb_pkg::POS_ML +: 3];
   assign i2c3_slave_prio = regVal[4][iprb_pkg::POS_LO +: 3];
   assign spi3_event_prio = regVal[5][iprb_pkg::POS_HI +: 3];
   assign spi3_fault_prio = regVal[5][iprb_pkg::POS_MH +: 3];
   assign uart4_tx_prio = regVal[5][iprb_pkg::POS_ML +: 3];
   assign uart4_rx_prio = regVal[5][iprb_pkg::POS_LO +: 3];

   // zero level disables the source; arbiter must gate its request with this
   // per source from bit 0 (uart4 rx) up to bit 15 (crc): holding register, field low bit
   localparam int SRC_REG [16] = '{5, 5, 5, 5, 4, 4, 4, 4, 3, 3, 3, 2, 1, 0, 0, 0};
   localparam int SRC_POS [16] = '{
      iprb_pkg::POS_LO, iprb_pkg::POS_ML, iprb_pkg::POS_MH, iprb_pkg::POS_HI,
      iprb_pkg::POS_LO, iprb_pkg::POS_ML, iprb_pkg::POS_MH, iprb_pkg::POS_HI,
      iprb_pkg::POS_ML, iprb_pkg::POS_MH, iprb_pkg::POS_HI, iprb_pkg::POS_ML,
      iprb_pkg::POS_LO, iprb_pkg::POS_ML, iprb_pkg::POS_MH, iprb_pkg::POS_HI};
   logic [15:0] srcEnable_reg;
   wire logic [15:0] srcEnable_next;

   generate
      for (gi = 0; gi < 16; gi++) begin : g_en
         assign srcEnable_next[gi] =
            (regNext[SRC_REG[gi]][SRC_POS[gi] +: 3] != iprb_pkg::PRIO_OFF);
      end
   endgenerate

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         srcEnable_reg <= {16{iprb_pkg::PRIO_RESET != iprb_pkg::PRIO_OFF}};
      end else begin
         srcEnable_reg <= srcEnable_next;
      end
   end

   assign srcEnable = srcEnable_reg;

   //---------------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------------
   sequence s_wrCommit;
      wrFire && wrHit[4] && (wStrb_reg[1:0] == 2'h3);
   endsequence

   property p_writeLands;
      @(posedge core_clk) disable iff (!arst_n)
      s_wrCommit |=> (regVal[4] == ($past(wData_reg[15:0]) & iprb_pkg::MASK_UART4_USB_I2C3));
   endproperty
   a_writeLands: assert property (p_writeLands) else $error("write not stored");

   property p_noStray;
      @(posedge core_clk) disable iff (!arst_n)
      (regVal[1][15:3] == 13'h0000) && (regVal[2][15:7] == 9'h000) && (regVal[2][3:0] == 4'h0);
   endproperty
   a_noStray: assert property (p_noStray) else $error("unimplemented bit set");

   property p_readZeroUpper;
      @(posedge core_clk) disable iff (!arst_n)
      s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000) && (s_axi_rdata[15] == 1'b0);
   endproperty
   a_readZeroUpper: assert property (p_readZeroUpper) else $error("reserved read nonzero");

   property p_disable;
      @(posedge core_clk) disable iff (!arst_n)
      (usb_otg_prio == 3'h0) |-> !srcEnable[6];
   endproperty
   a_disable: assert property (p_disable) else $error("zero level still enabled");

   property p_enable;
      @(posedge core_clk) disable iff (!arst_n)
      (crc_error_prio != 3'h0) |-> srcEnable[15];
   endproperty
   a_enable: assert property (p_enable) else $error("nonzero level disabled");

   property p_resetLevel;
      @(posedge core_clk)
      $rose(arst_n) |-> (low_voltage_prio == 3'h4) && (uart4_rx_prio == 3'h4);
   endproperty
   a_resetLevel: assert property (p_resetLevel) else $error("reset level not 4");

   property p_stableNoWrite;
      @(posedge core_clk) disable iff (!arst_n)
      !wrFire |=> $stable(regVal[3]);
   endproperty
   a_stableNoWrite: assert property (p_stableNoWrite) else $error("field changed w/o write");

   property p_readAnswer;
      @(posedge core_clk) disable iff (!arst_n)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
   endproperty
   a_readAnswer: assert property (p_readAnswer) else $error("read not answered");

   property p_readyTrack;
      @(posedge core_clk) disable iff (!arst_n)
      (s_axi_awready == (!awHeld_reg && !bValid_reg)) &&
      (s_axi_wready == (!wHeld_reg && !bValid_reg)) && (s_axi_arready == !rValid_reg);
   endproperty
   a_readyTrack: assert property (p_readyTrack) else $error("ready out of step");

   sequence s_bothTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   sequence s_commitAnswer;
      wrFire ##1 s_axi_bvalid;
   endsequence

   property p_writeAnswer;
      @(posedge core_clk) disable iff (!arst_n)
      s_bothTaken |=> s_commitAnswer;
   endproperty
   a_writeAnswer: assert property (p_writeAnswer) else $error("write not answered");

   property p_unmappedWrite;
      @(posedge core_clk) disable iff (!arst_n)
      (wrFire && !wrMapped) |=> (s_axi_bresp == iprb_pkg::RESP_SLVERR) &&
         $stable(regVal[0]) && $stable(regVal[5]);
   endproperty
   a_unmappedWrite: assert property (p_unmappedWrite) else $error("unmapped write stored");

   property p_unmappedRead;
      @(posedge core_clk) disable iff (!arst_n)
      (s_axi_arvalid && s_axi_arready && !rdMapped) |=>
         (s_axi_rresp == iprb_pkg::RESP_SLVERR) && (s_axi_rdata == 32'h0000_0000);
   endproperty
   a_unmappedRead: assert property (p_unmappedRead) else $error("unmapped read not refused");

   property p_resetEnable;
      @(posedge core_clk)
      $rose(arst_n) |-> (&srcEnable) && (crc_error_prio == iprb_pkg::PRIO_RESET);
   endproperty
   a_resetEnable: assert property (p_resetEnable) else $error("source off after reset");

   // every enable bit must follow its own field in the same cycle, no lag allowed
   generate
      for (gi = 0; gi < 16; gi++) begin : g_enChk
         property p_enableTrack;
            @(posedge core_clk) disable iff (!arst_n)
            srcEnable[gi] == (regVal[SRC_REG[gi]][SRC_POS[gi] +: 3] != iprb_pkg::PRIO_OFF);
         endproperty
         a_enableTrack: assert property (p_enableTrack) else $error("enable out of step");
      end
   endgenerate
endmodule // iprb_interrupt_priority_regs

// ---- iprb_pkg.sv ----
// package: register map, field layout and reset values of the upper priority bank
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package iprb_pkg;
   localparam int NUM_REGS = 6;
   localparam int ADDR_W = 5;
   // byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFS_CRC_UART_ERR = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_LOW_VOLTAGE = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_CHARGE_TIME = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_UART3 = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_UART4_USB_I2C3 = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_SPI3_UART4 = 5'h14;
   // implemented-bit masks per register
   localparam logic [15:0] MASK_CRC_UART_ERR = 16'h7770;
   localparam logic [15:0] MASK_LOW_VOLTAGE = 16'h0007;
   localparam logic [15:0] MASK_CHARGE_TIME = 16'h0070;
   localparam logic [15:0] MASK_UART3 = 16'h7770;
   localparam logic [15:0] MASK_UART4_USB_I2C3 = 16'h7777;
   localparam logic [15:0] MASK_SPI3_UART4 = 16'h7777;
   // field positions (low bit)
   localparam int POS_HI = 12;
   localparam int POS_MH = 8;
   localparam int POS_ML = 4;
   localparam int POS_LO = 0;
   // reset: every field at priority 4
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [15:0] RST_ALL_FIELDS = 16'h4444;
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- iprb_prio_reg.sv ----
// one priority register: masked storage with byte strobes
module iprb_prio_reg #(
   parameter logic [15:0] MASK = 16'h0000
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // write port
   input wire logic wrEn,
   input wire logic [15:0] wrData,
   input wire logic [1:0] wrStrb,
   // contents
   output logic [15:0] value
);
   logic [15:0] value_reg;
   logic [15:0] value_next;
   wire logic [15:0] laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}} & MASK;

   // unimplemented positions never store anything
   assign value_next = (value_reg & ~laneMask) | (wrData & laneMask);
   assign value = value_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         value_reg <= iprb_pkg::RST_ALL_FIELDS & MASK;
      end else if (wrEn) begin
         value_reg <= value_next;
      end
   end
endmodule // iprb_prio_reg

// ---- test_interrupt_priority_regs_upper.sv ----
// testbench: axi4-lite checks of the upper interrupt priority bank
module test_interrupt_priority_regs_upper;
   timeunit 1ns;
   timeprecision 1ps;
   //---------------------------------------------------------------
   // signals and reference state
   //---------------------------------------------------------------
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] p0, p1, p2, p3, p4, p5, p6, p7, p8, p9, p10, p11, p12, p13, p14, p15;
   logic [15:0] srcEnable;
   logic [15:0] expReg [6];
   logic [33:0] rdQ [$];
   logic [1:0] bQ [$];
   logic [33:0] rdExp;
   logic [31:0] rndData;
   logic [3:0] rndStrb;
   int bad_count = 0;
   int checked = 0;
   int n;
   // own index for the random scenario: the wait loops reuse n
   int sel;
   localparam logic [15:0] MASKS [6] = '{iprb_pkg::MASK_CRC_UART_ERR, iprb_pkg::MASK_LOW_VOLTAGE,
      iprb_pkg::MASK_CHARGE_TIME, iprb_pkg::MASK_UART3, iprb_pkg::MASK_UART4_USB_I2C3,
      iprb_pkg::MASK_SPI3_UART4};
   localparam logic [4:0] OFS [6] = '{iprb_pkg::OFS_CRC_UART_ERR, iprb_pkg::OFS_LOW_VOLTAGE,
      iprb_pkg::OFS_CHARGE_TIME, iprb_pkg::OFS_UART3, iprb_pkg::OFS_UART4_USB_I2C3,
      iprb_pkg::OFS_SPI3_UART4};

   always #2 core_clk = ~core_clk;

   iprb_interrupt_priority_regs dut (.core_clk(core_clk), .arst_n(arst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .crc_error_prio(p0), .uart2_error_prio(p1), .uart1_error_prio(p2),
      .low_voltage_prio(p3), .charge_time_prio(p4), .uart3_tx_prio(p5), .uart3_rx_prio(p6),
      .uart3_error_prio(p7), .uart4_error_prio(p8), .usb_otg_prio(p9),
      .i2c3_master_prio(p10), .i2c3_slave_prio(p11), .spi3_event_prio(p12),
      .spi3_fault_prio(p13), .uart4_tx_prio(p14), .uart4_rx_prio(p15), .srcEnable(srcEnable));

   //---------------------------------------------------------------
   // shared tasks
   //---------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic hang;
      bad_count++;
      $display("[ERR] handshake expected answer seen none");
      end_sim();
   endtask

   // write with lane strobes; an unmapped place expects slverr and no update
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [15:0] lane;
      logic [1:0] resp;
      resp = iprb_pkg::RESP_SLVERR;
      for (int k = 0; k < 6; k++) begin
         if (OFS[k] === a) begin
            lane = {{8{s[1]}}, {8{s[0]}}} & MASKS[k];
            expReg[k] = (expReg[k] & ~lane) | (d[15:0] & lane);
            resp = iprb_pkg::RESP_OKAY;
         end
      end
      bQ.push_back(resp);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 64) hang();
   endtask

   task automatic rd(input logic [4:0] a);
      logic [33:0] e;
      e = {iprb_pkg::RESP_SLVERR, 32'h0000_0000};
      for (int k = 0; k < 6; k++) begin
         if (OFS[k] === a) e = {iprb_pkg::RESP_OKAY, 16'h0000, expReg[k]};
      end
      rdQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 64) hang();
   endtask

   task automatic chk_out;
      logic [47:0] f;
      logic [15:0] en;
      f = {expReg[0][14:12], expReg[0][10:8], expReg[0][6:4], expReg[1][2:0], expReg[2][6:4],
         expReg[3][14:12], expReg[3][10:8], expReg[3][6:4], expReg[4][14:12], expReg[4][10:8],
         expReg[4][6:4], expReg[4][2:0], expReg[5][14:12], expReg[5][10:8], expReg[5][6:4],
         expReg[5][2:0]};
      // enable bits follow the field order, first field (crc) on the top bit
      for (int i = 0; i < 16; i++) en[15 - i] = (f[47 - 3 * i -: 3] != iprb_pkg::PRIO_OFF);
      chk("fields", {p0, p1, p2, p3, p4, p5, p6, p7, p8, p9, p10, p11, p12, p13, p14, p15},
         f);
      chk("enable", {32'h0, srcEnable}, {32'h0, en});
   endtask

   task automatic read_all;
      for (int k = 0; k < 6; k++) rd(OFS[k]);
      chk_out();
   endtask

   task automatic reset_model;
      for (int k = 0; k < 6; k++) expReg[k] = iprb_pkg::RST_ALL_FIELDS & MASKS[k];
   endtask

   // responses are compared in arrival order against the notes of the driver
   always @(posedge core_clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         rdExp = (rdQ.size() > 0) ? rdQ.pop_front() : 34'h3_ffff_ffff;
         chk("rdata", {16'h0000, s_axi_rdata}, {16'h0000, rdExp[31:0]});
         chk("rresp", {46'h0, s_axi_rresp}, {46'h0, rdExp[33:32]});
      end
      if (s_axi_bvalid && s_axi_bready) begin
         chk("bresp", {46'h0, s_axi_bresp},
            {46'h0, (bQ.size() > 0) ? bQ.pop_front() : 2'h3});
      end
   end

   //---------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      void'($urandom(6157));
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      reset_model();
      @(posedge core_clk);
      read_all();
      chk("enable_reset", {32'h0, srcEnable}, 48'h0000_0000_ffff);
      for (int k = 0; k < 6; k++) wr(OFS[k], 32'hffff_ffff, 4'hf);
      read_all();
      for (int k = 0; k < 6; k++) wr(OFS[k], 32'hffff_ff00, 4'h1);
      read_all();
      for (int k = 0; k < 6; k++) wr(OFS[k], 32'hffff_00ff, 4'ha);
      read_all();
      chk("enable_off", {32'h0, srcEnable}, 48'h0);
      for (int lvl = 1; lvl < 8; lvl++) begin
         for (int k = 0; k < 6; k++) wr(OFS[k], {16'h0000, {4{1'b0, 3'(lvl)}}}, 4'h3);
         read_all();
         chk("enable_on", {32'h0, srcEnable}, 48'h0000_0000_ffff);
      end
      wr(5'h18, 32'h0000_0000, 4'hf);
      rd(5'h1c);
      read_all();
      repeat (40) begin
         sel = $urandom_range(0, 6);
         rndData = $urandom;
         rndStrb = 4'($urandom);
         wr((sel < 6) ? OFS[sel] : 5'h1c, rndData, rndStrb);
         rd((sel < 6) ? OFS[sel] : 5'h18);
         chk_out();
      end
      arst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      reset_model();
      @(posedge core_clk);
      read_all();
      @(posedge core_clk);
      end_sim();
   end
endmodule // test_interrupt_priority_regs_upper
